// ---- hw/tcpu_regs.vh ----
`ifndef TCPU_REGS_VH
`define TCPU_REGS_VH
// Register word offsets.
`define TCPU_CTRL_OFF 4'h0
`define TCPU_PERIOD_OFF 4'h1
`define TCPU_CMP_OFF 4'h2
`define TCPU_DEAD_OFF 4'h3
`define TCPU_CAPT_OFF 4'h4
`define TCPU_COUNT_OFF 4'h5
`define TCPU_STAT_OFF 4'h6
// Control field positions.
`define TCPU_CTRL_RUN 0
`define TCPU_CTRL_AUTO 1
`define TCPU_CTRL_DOWN 2
`define TCPU_CTRL_KILLV 3
`define TCPU_CTRL_CSEL_LO 4
`define TCPU_CTRL_SSEL_LO 8
`define TCPU_CTRL_KEN 12
// Reset values.
`define TCPU_CTRL_RST 32'h0000_0002
`define TCPU_PERIOD_RST 16'hffff
`define TCPU_CMP_RST 16'h8000
`define TCPU_DEAD_RST 8'h00
`endif

// ---- hw/tcpu_timer_counter_pwm_unit.v ----
`timescale 1ns/10ps
`include "tcpu_regs.vh"
// What this block does
// - Sixteen-bit counter, period set by software.
// - Capture event copies count to capture register.
// - Capture source selectable, pins among sources.
// - At period, halt or reload per configuration.
// - Compare against counter gives PWM duty output.
// - True and complement outputs with dead band.
// - Kill input forces outputs safe once its pin filter settles.
// - Five pin triggers start or capture.
module tcpu_timer_counter_pwm_unit #(
  parameter WIDTH = 16,
  parameter NTRIG = 5
) (
  input wire clk,
  input wire rst_n,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [NTRIG-1:0] pin_trigger_in,
  input wire kill_in,
  output reg pwm_true_out,
  output reg pwm_complement_out,
  output reg overflow_out,
  output reg underflow_out,
  output reg match_out
);
  reg [31:0] ctrl_reg;
  reg [WIDTH-1:0] period_reg;
  reg [WIDTH-1:0] cmp_reg;
  reg [7:0] dead_reg;
  reg [WIDTH-1:0] capt_reg;
  reg [WIDTH-1:0] count_reg;
  reg capt_flag_reg;
  reg done_reg;
  reg [NTRIG-1:0] s1_reg;
  reg [NTRIG-1:0] s2_reg;
  reg [NTRIG-1:0] s3_reg;
  reg [NTRIG-1:0] trig_lvl_reg;
  reg [NTRIG-1:0] trig_prev_reg;
  reg k1_reg;
  reg k2_reg;
  reg k3_reg;
  reg kill_lvl_reg;
  reg pwm_raw_reg;
  reg pwm_prev_reg;
  reg [7:0] dead_cnt_reg;
  reg ack_reg;
  reg sw_capt_reg;
  // Avalon: one wait cycle, answer on the following edge.
  // A write lands on the edge that takes it, the same edge on which waitrequest drops.
  // This keeps the answer a plain flop, at the cost of one wait state per access.
  wire req = (avs_read | avs_write) & ~ack_reg;
  wire wr = avs_write & req;
  wire [NTRIG-1:0] trig_rise = trig_lvl_reg & ~trig_prev_reg;
  wire [2:0] csel = ctrl_reg[`TCPU_CTRL_CSEL_LO +: 3];
  wire [2:0] ssel = ctrl_reg[`TCPU_CTRL_SSEL_LO +: 3];
  wire run = ctrl_reg[`TCPU_CTRL_RUN];
  wire down = ctrl_reg[`TCPU_CTRL_DOWN];
  // Source codes 0..4 pick a pin edge, 5 picks a software strobe for capture only, others none.
  wire capt_evt = (csel < NTRIG) ? trig_rise[csel] : (csel == 3'h5 ? sw_capt_reg : 1'b0);
  wire start_evt = (ssel < NTRIG) ? trig_rise[ssel] : 1'b0;
  wire at_end = down ? (count_reg == {WIDTH{1'b0}}) : (count_reg == period_reg);
  wire kill = kill_lvl_reg & ctrl_reg[`TCPU_CTRL_KEN];
  wire killv = ctrl_reg[`TCPU_CTRL_KILLV];
  // Zero bits that pad a counter-wide register up to the bus word.
  localparam PAD = 32 - WIDTH;
  // Unmapped words read as zero, so software probing them never sees stale data.
  reg [31:0] rdata_next;
  always @* begin
    case (avs_address)
      `TCPU_CTRL_OFF: rdata_next = ctrl_reg;
      `TCPU_PERIOD_OFF: rdata_next = {{PAD{1'b0}}, period_reg};
      `TCPU_CMP_OFF: rdata_next = {{PAD{1'b0}}, cmp_reg};
      `TCPU_DEAD_OFF: rdata_next = {24'h000000, dead_reg};
      `TCPU_CAPT_OFF: rdata_next = {{PAD{1'b0}}, capt_reg};
      `TCPU_COUNT_OFF: rdata_next = {{PAD{1'b0}}, count_reg};
      `TCPU_STAT_OFF: rdata_next = {29'h0, kill_lvl_reg, done_reg, capt_flag_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end
  integer b;
  always @(posedge clk) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      ctrl_reg <= `TCPU_CTRL_RST;
      period_reg <= `TCPU_PERIOD_RST;
      cmp_reg <= `TCPU_CMP_RST;
      dead_reg <= `TCPU_DEAD_RST;
      sw_capt_reg <= 1'b0;
    end else begin
      ack_reg <= req;
      avs_waitrequest <= ~req;
      sw_capt_reg <= 1'b0;
      if (req)
        avs_readdata <= rdata_next;
      if (wr) begin
        case (avs_address)
          `TCPU_CTRL_OFF: for (b = 0; b < 4; b = b + 1)
            if (avs_byteenable[b])
              ctrl_reg[b*8 +: 8] <= avs_writedata[b*8 +: 8];
          `TCPU_PERIOD_OFF: for (b = 0; b < 2; b = b + 1)
            if (avs_byteenable[b])
              period_reg[b*8 +: 8] <= avs_writedata[b*8 +: 8];
          `TCPU_CMP_OFF: for (b = 0; b < 2; b = b + 1)
            if (avs_byteenable[b])
              cmp_reg[b*8 +: 8] <= avs_writedata[b*8 +: 8];
          `TCPU_DEAD_OFF: if (avs_byteenable[0])
            dead_reg <= avs_writedata[7:0];
          `TCPU_CAPT_OFF: sw_capt_reg <= avs_byteenable[0] & avs_writedata[0];
          default: ;
        endcase
      end
      // A pin start trigger sets run; a halt at period clears it.
      if (start_evt)
        ctrl_reg[`TCPU_CTRL_RUN] <= 1'b1;
      else if (run && at_end && !ctrl_reg[`TCPU_CTRL_AUTO])
        ctrl_reg[`TCPU_CTRL_RUN] <= 1'b0;
    end
  end
  // Pin inputs: three flops, change accepted once the second and third agree.
  // The agreement gives hysteresis: a one-cycle glitch cannot make a false edge,
  // at the price of one more cycle of latency from pin to event.
  always @(posedge clk) begin
    if (!rst_n) begin
      s1_reg <= {NTRIG{1'b0}};
      s2_reg <= {NTRIG{1'b0}};
      s3_reg <= {NTRIG{1'b0}};
      trig_lvl_reg <= {NTRIG{1'b0}};
      trig_prev_reg <= {NTRIG{1'b0}};
      k1_reg <= 1'b0;
      k2_reg <= 1'b0;
      k3_reg <= 1'b0;
      kill_lvl_reg <= 1'b0;
    end else begin
      s1_reg <= pin_trigger_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      trig_lvl_reg <= (s2_reg & s3_reg) | (trig_lvl_reg & (s2_reg | s3_reg));
      trig_prev_reg <= trig_lvl_reg;
      k1_reg <= kill_in;
      k2_reg <= k1_reg;
      k3_reg <= k2_reg;
      if (k2_reg == k3_reg)
        kill_lvl_reg <= k3_reg;
    end
  end
  // Counter, capture and event pulses.
  always @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= {WIDTH{1'b0}};
      capt_reg <= {WIDTH{1'b0}};
      capt_flag_reg <= 1'b0;
      done_reg <= 1'b0;
      overflow_out <= 1'b0;
      underflow_out <= 1'b0;
      match_out <= 1'b0;
    end else begin
      overflow_out <= 1'b0;
      underflow_out <= 1'b0;
      match_out <= run && (count_reg == cmp_reg);
      // A capture in the same cycle as a software clear wins, so no event is lost.
      if (capt_evt) begin
        capt_reg <= count_reg;
        capt_flag_reg <= 1'b1;
      end else if (wr && avs_address == `TCPU_STAT_OFF && avs_writedata[0])
        capt_flag_reg <= 1'b0;
      if (start_evt)
        done_reg <= 1'b0;
      else if (run && at_end && !ctrl_reg[`TCPU_CTRL_AUTO])
        done_reg <= 1'b1;
      // Without auto reload the count parks on its limit, so software reads where it stopped.
      if (run) begin
        if (at_end) begin
          if (ctrl_reg[`TCPU_CTRL_AUTO])
            count_reg <= down ? period_reg : {WIDTH{1'b0}};
          overflow_out <= ~down;
          underflow_out <= down;
        end else
          count_reg <= down ? count_reg - 1'b1 : count_reg + 1'b1;
      end
    end
  end
  // PWM and dead band: each output turns on only after the delay expires.
  // Even a dead value of zero blanks both outputs for one cycle on every change.
  // That costs a little duty range; only a kill with killv set drives both switches at once.
  always @(posedge clk) begin
    if (!rst_n) begin
      pwm_raw_reg <= 1'b0;
      pwm_prev_reg <= 1'b0;
      dead_cnt_reg <= 8'h00;
      pwm_true_out <= 1'b0;
      pwm_complement_out <= 1'b0;
    end else begin
      pwm_raw_reg <= count_reg < cmp_reg;
      pwm_prev_reg <= pwm_raw_reg;
      if (pwm_raw_reg != pwm_prev_reg)
        dead_cnt_reg <= dead_reg;
      else if (dead_cnt_reg != 8'h00)
        dead_cnt_reg <= dead_cnt_reg - 8'h01;
      if (kill) begin
        // Kill bypasses software and the dead-band counter entirely.
        pwm_true_out <= killv;
        pwm_complement_out <= killv;
      end else if (pwm_raw_reg != pwm_prev_reg || dead_cnt_reg != 8'h00) begin
        pwm_true_out <= 1'b0;
        pwm_complement_out <= 1'b0;
      end else begin
        pwm_true_out <= pwm_raw_reg;
        pwm_complement_out <= ~pwm_raw_reg;
      end
    end
  end
endmodule // tcpu_timer_counter_pwm_unit

// ---- verification/tcpu_asserts.sv ----
`timescale 1ns/10ps
module tcpu_asserts(
  input wire clk,
  input wire rst_n,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire kill_in,
  input wire pwm_true_out,
  input wire pwm_complement_out,
  input wire overflow_out,
  input wire underflow_out
);
  // Cycles since the kill pin was last high. Only a kill may move both outputs at once.
  logic [3:0] kage_reg;
  always @(posedge clk) kage_reg <= (!rst_n || kill_in) ? 4'h0 : kage_reg + {3'h0, kage_reg != 4'hf};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    (avs_read || avs_write) && avs_waitrequest && $past(avs_waitrequest);
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_take_answer: assert property (s_take |=> s_answer) else $error("bus answer late or long");
  a_idle_wait: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest) else $error("bus answer unasked");
  a_gap_true: assert property ($rose(pwm_true_out) && !pwm_complement_out |-> !$past(pwm_complement_out)) else $error("no dead band before true");
  a_gap_comp: assert property ($rose(pwm_complement_out) && !pwm_true_out |-> !$past(pwm_true_out)) else $error("no dead band before complement");
  a_one_edge: assert property (!(overflow_out && underflow_out)) else $error("overflow with underflow");
  a_ovf_pulse: assert property (overflow_out |=> !overflow_out) else $error("overflow pulse too long");
  a_unf_pulse: assert property (underflow_out |=> !underflow_out) else $error("underflow pulse too long");
  a_kill_pair: assert property ($changed(pwm_true_out) && $changed(pwm_complement_out) |-> kage_reg < 4'h8) else $error("outputs switched together");
endmodule // tcpu_asserts
bind tcpu_timer_counter_pwm_unit tcpu_asserts u_chk(
  .clk(clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .kill_in(kill_in), .pwm_true_out(pwm_true_out), .pwm_complement_out(pwm_complement_out),
  .overflow_out(overflow_out), .underflow_out(underflow_out)
);

// ---- verification/tcpu_pins_model.sv ----
`timescale 1ns/10ps
module tcpu_pins_model(
  input wire clk,
  input wire fire,
  input wire [2:0] fire_idx,
  input wire kill_req,
  output logic [4:0] pin_trigger_in = 5'h00,
  output logic kill_in = 1'b0
);
  // A source holds its level while fired, so the unit's pin filter sees a steady edge.
  always @(posedge clk) begin
    pin_trigger_in <= fire ? 5'h01 << fire_idx : 5'h00;
    kill_in <= kill_req;
  end
endmodule // tcpu_pins_model

// ---- verification/tcpu_timer_counter_pwm_unit_tb.sv ----
`timescale 1ns/10ps
module tcpu_timer_counter_pwm_unit_tb;
  logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, fire = 1'b0, kill_req = 1'b0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [2:0] fire_idx = 3'h0;
  logic [4:0] pin_trigger_in;
  logic kill_in, avs_waitrequest, pwm_true_out, pwm_complement_out, overflow_out, underflow_out, match_out;
  int miscompares = 0, compares = 0;
  // Four-state counts, so an unknown output shows up as a mismatch instead of a zero.
  logic [31:0] n_o, n_u, n_t, n_c, n_m;
  // Each row: word index in the top nibble beside the value it must read after reset.
  logic [35:0] rows [8] = '{36'h0_00000002, 36'h1_0000ffff, 36'h2_00008000, 36'h3_00000000,
    36'h5_00000000, 36'h6_00000000, 36'h7_00000000, 36'hf_00000000};
  tcpu_timer_counter_pwm_unit u_dut(
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_trigger_in(pin_trigger_in), .kill_in(kill_in),
    .pwm_true_out(pwm_true_out), .pwm_complement_out(pwm_complement_out), .overflow_out(overflow_out),
    .underflow_out(underflow_out), .match_out(match_out)
  );
  tcpu_pins_model u_pins(
    .clk(clk), .fire(fire), .fire_idx(fire_idx), .kill_req(kill_req), .pin_trigger_in(pin_trigger_in),
    .kill_in(kill_in)
  );
  initial forever #4 clk = ~clk;
  task close_out;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // No cycle count is assumed; the watchdog ends a wait that never finishes.
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task cnt;
    {n_o, n_u, n_t, n_c, n_m} = 0;
    repeat (100) begin
      @(posedge clk);
      n_o += overflow_out;
      n_u += underflow_out;
      n_t += pwm_true_out;
      n_c += pwm_complement_out;
      n_m += match_out;
    end
  endtask
  task fire_pin(input int i);
    fire_idx <= i[2:0];
    fire <= 1'b1;
    repeat (3) @(posedge clk);
    fire <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b0, rows[i][35:32], 32'h0);
      chk("reset value", rows[i][31:0], q);
    end
    bus(1'b1, 4'h1, 32'h9);
    bus(1'b1, 4'h2, 32'h4);
    bus(1'b1, 4'h3, 32'h1);
    bus(1'b1, 4'h0, 32'h3);
    repeat (20) @(posedge clk);
    cnt();
    chk("overflows", 10, n_o);
    chk("no underflow counting up", 0, n_u);
    chk("matches", 10, n_m);
    // Period of ten with compare four; each change of the raw level blanks both outputs for two cycles.
    chk("true high", 20, n_t);
    chk("complement high", 40, n_c);
    bus(1'b1, 4'h0, 32'h7);
    repeat (20) @(posedge clk);
    cnt();
    chk("underflows", 10, n_u);
    chk("no overflow counting down", 0, n_o);
    bus(1'b1, 4'h0, 32'h1);
    repeat (30) @(posedge clk);
    bus(1'b0, 4'h5, 32'h0);
    chk("halted count", 9, q);
    bus(1'b0, 4'h0, 32'h0);
    chk("run cleared", 0, q[0]);
    bus(1'b0, 4'h6, 32'h0);
    chk("halted status", 32'h2, q);
    for (int i = 0; i < 5; i++) begin
      // Start source is a pin never fired here, so the stopped count stays put.
      bus(1'b1, 4'h0, (i << 4) | (((i + 3) % 5) << 8));
      bus(1'b1, 4'h6, 32'h1);
      fire_pin((i + 1) % 5);
      bus(1'b0, 4'h6, 32'h0);
      chk("foreign pin capture", 0, q[0]);
      fire_pin(i);
      bus(1'b0, 4'h6, 32'h0);
      chk("capture flag", 1, q[0]);
      bus(1'b0, 4'h4, 32'h0);
      chk("captured count", 9, q);
    end
    // Pin 2 starts a stopped down count from nine; it halts on reaching zero.
    bus(1'b1, 4'h0, 32'h204);
    fire_pin(2);
    repeat (20) @(posedge clk);
    bus(1'b0, 4'h5, 32'h0);
    chk("started count", 0, q);
    // Software strobe as capture source.
    bus(1'b1, 4'h0, 32'h50);
    bus(1'b1, 4'h6, 32'h1);
    bus(1'b1, 4'h4, 32'h1);
    bus(1'b0, 4'h4, 32'h0);
    chk("software capture", 0, q);
    bus(1'b0, 4'h6, 32'h0);
    chk("software capture flag", 1, q[0]);
    bus(1'b1, 4'h0, 32'h100b);
    kill_req <= 1'b1;
    repeat (10) @(posedge clk);
    chk("killed outputs", 3, {pwm_true_out, pwm_complement_out});
    bus(1'b1, 4'h0, 32'h1003);
    repeat (2) @(posedge clk);
    chk("killed low", 0, {pwm_true_out, pwm_complement_out});
    kill_req <= 1'b0;
    repeat (30) @(posedge clk);
    cnt();
    chk("true after kill", 20, n_t);
    // Reset again in mid-run: outputs idle, waitrequest high, control back to its reset value.
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("outputs in reset", 1, {pwm_true_out, pwm_complement_out, overflow_out, underflow_out, match_out,
      avs_waitrequest});
    rst_n <= 1'b1;
    bus(1'b0, 4'h0, 32'h0);
    chk("control after reset", 32'h2, q);
    close_out();
  end
  initial begin
    #200000;
    miscompares++;
    close_out();
  end
endmodule // tcpu_timer_counter_pwm_unit_tb
